// *** design/audio_capture_path_control.sv ***
// register bank and ADC1 channel routing of the capture path
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - registers sit in page 1 at their offset, and at 0xA1 plus offset
// - two filter control registers govern the ADC0 and ADC1 high-pass
// - hold bit 4 freezes the filter; resets to 0
// - bypass bit 6 disables the filter; resets to 0
// - bit 7 of each gain register mutes that channel; resets muted
// - muting silences the gain stage, sample stream keeps running
// - ADC1 gain has sixteen 1.5 dB steps, 22.5 dB down to 0 dB
// - gain field bits 3:0, 0h largest, Fh is 0 dB, resets Fh
// - digital boost sits after conversion, before the gain stage
// - bit 0 selects analog mic when 0, digital when 1; resets analog
// - shared pins carry digital mic or analog mic functions by mode
// - exchange bit 1 swaps left and right ADC1 outputs
// - mono bit 2 copies left to right after the exchange
// - exchange and mono give stereo, left mono or right mono capture
// - polarity bit 3 inverts every incoming microphone bit
// - bit 7 powers down analog mic circuits; resets powered down
// - analog boost bits 1:0 right, 5:4 left, 0..30 dB, reset 00b
module audio_capture_path_control #(
    parameter int SAMPLE_W = capture_path_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic                MCLK,
    input  wire logic                SYS_RST,
    // register port, slave page access
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    input  wire logic [7:0]          REG_PAGE,
    input  wire logic [7:0]          REG_OFFSET,
    // register port, microcontroller access
    input  wire logic                UC_WR,
    input  wire logic                UC_RD,
    input  wire logic [15:0]         UC_ADDR,
    // shared write data and read answer
    input  wire logic [7:0]          REG_WDATA,
    output logic      [7:0]          REG_RDATA,
    output logic                     REG_HIT,
    // microphone bits, raw in and after polarity handling out
    input  wire logic                MIC_BIT_A,
    input  wire logic                MIC_BIT_B,
    output logic                     MIC_BIT_A_OUT,
    output logic                     MIC_BIT_B_OUT,
    // ADC1 sample stream in
    input  wire logic                ADC1_VALID,
    input  wire logic [SAMPLE_W-1:0] ADC1_LEFT,
    input  wire logic [SAMPLE_W-1:0] ADC1_RIGHT,
    // ADC1 sample stream out
    output logic                     OUT_VALID,
    output logic [SAMPLE_W-1:0]      OUT_LEFT,
    output logic [SAMPLE_W-1:0]      OUT_RIGHT,
    // filter controls
    output logic                     ADC0_HPF_HOLD,
    output logic                     ADC0_HPF_BYPASS,
    output logic                     ADC1_HPF_HOLD,
    output logic                     ADC1_HPF_BYPASS,
    // port mode and analog controls
    output logic                     DIGITAL_MICROPHONE_PORT_SETUP,
    output logic                     DIGITAL_PINS_EN,
    output logic                     ANALOG_PINS_EN,
    output logic                     ANALOG_MIC_POWERDOWN,
    output logic [1:0]               LEFT_ANALOG_BOOST,
    output logic [1:0]               RIGHT_ANALOG_BOOST
);
    logic [7:0] adc0_filter_ctrl_q;
    logic [7:0] adc1_left_digital_gain_q;
    logic [7:0] adc1_right_digital_gain_q;
    logic [7:0] adc1_boost_select_q;
    logic [7:0] adc1_filter_ctrl_q;
    logic [7:0] microphone_port_setup_q;
    logic [7:0] analog_mic_gain_select_q;
    logic       wr_en;
    logic       rd_en;
    logic       page_hit;
    logic       uc_hit;
    logic [7:0] ofs;
    logic [7:0] rdata_d;
    logic       known_d;
    logic       gl_valid;
    logic       gr_valid;
    logic [SAMPLE_W-1:0] gl_data;
    logic [SAMPLE_W-1:0] gr_data;
    logic [SAMPLE_W-1:0] sw_left;
    logic [SAMPLE_W-1:0] sw_right;

    // both access paths decode to the same offset
    always_comb begin
        page_hit = (REG_WR || REG_RD) && REG_PAGE == capture_path_pkg::PAGE_AUDIO;
        uc_hit   = (UC_WR || UC_RD)
                   && UC_ADDR[15:8] == capture_path_pkg::UC_PREFIX;
        ofs      = page_hit ? REG_OFFSET : UC_ADDR[7:0];
        wr_en    = (page_hit && REG_WR) || (!page_hit && uc_hit && UC_WR);
        rd_en    = (page_hit && REG_RD) || (!page_hit && uc_hit && UC_RD);
    end

    // full bytes stored, reserved bits included
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            adc0_filter_ctrl_q        <= capture_path_pkg::RST_FILT;
            adc1_left_digital_gain_q  <= capture_path_pkg::RST_GAIN;
            adc1_right_digital_gain_q <= capture_path_pkg::RST_GAIN;
            adc1_boost_select_q       <= capture_path_pkg::RST_BOOST;
            adc1_filter_ctrl_q        <= capture_path_pkg::RST_FILT;
            microphone_port_setup_q   <= capture_path_pkg::RST_MIC_SETUP;
            analog_mic_gain_select_q  <= capture_path_pkg::RST_AMIC_GAIN;
        end else if (wr_en) begin
            case (ofs)
                capture_path_pkg::OFS_ADC0_FILT:
                    adc0_filter_ctrl_q <= REG_WDATA;
                capture_path_pkg::OFS_ADC1_LGAIN:
                    adc1_left_digital_gain_q <= REG_WDATA;
                capture_path_pkg::OFS_ADC1_RGAIN:
                    adc1_right_digital_gain_q <= REG_WDATA;
                capture_path_pkg::OFS_ADC1_BOOST:
                    adc1_boost_select_q <= REG_WDATA;
                capture_path_pkg::OFS_ADC1_FILT:
                    adc1_filter_ctrl_q <= REG_WDATA;
                capture_path_pkg::OFS_MIC_SETUP:
                    microphone_port_setup_q <= REG_WDATA;
                capture_path_pkg::OFS_AMIC_GAIN:
                    analog_mic_gain_select_q <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // unmapped offsets read zero and report no hit
    always_comb begin
        known_d = 1'b1;
        case (ofs)
            capture_path_pkg::OFS_ADC0_FILT:  rdata_d = adc0_filter_ctrl_q;
            capture_path_pkg::OFS_ADC1_LGAIN: rdata_d = adc1_left_digital_gain_q;
            capture_path_pkg::OFS_ADC1_RGAIN:
                rdata_d = adc1_right_digital_gain_q;
            capture_path_pkg::OFS_ADC1_BOOST: rdata_d = adc1_boost_select_q;
            capture_path_pkg::OFS_ADC1_FILT:  rdata_d = adc1_filter_ctrl_q;
            capture_path_pkg::OFS_MIC_SETUP:  rdata_d = microphone_port_setup_q;
            capture_path_pkg::OFS_AMIC_GAIN:  rdata_d = analog_mic_gain_select_q;
            default: begin
                rdata_d = 8'h00;
                known_d = 1'b0;
            end
        endcase
    end

    // read data is registered, one cycle after the strobe
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
            REG_HIT   <= 1'b0;
        end else begin
            REG_RDATA <= rd_en ? rdata_d : 8'h00;
            REG_HIT   <= (rd_en || wr_en) && known_d;
        end
    end

    assign ADC0_HPF_HOLD   = adc0_filter_ctrl_q[capture_path_pkg::BIT_HPF_HOLD];
    assign ADC0_HPF_BYPASS =
        adc0_filter_ctrl_q[capture_path_pkg::BIT_HPF_BYPASS];
    assign ADC1_HPF_HOLD   = adc1_filter_ctrl_q[capture_path_pkg::BIT_HPF_HOLD];
    assign ADC1_HPF_BYPASS =
        adc1_filter_ctrl_q[capture_path_pkg::BIT_HPF_BYPASS];

    // pin function follows the mode bit
    assign DIGITAL_MICROPHONE_PORT_SETUP =
        microphone_port_setup_q[capture_path_pkg::BIT_MIC_TYPE];
    assign DIGITAL_PINS_EN  = DIGITAL_MICROPHONE_PORT_SETUP;
    assign ANALOG_PINS_EN   = !DIGITAL_MICROPHONE_PORT_SETUP;
    assign ANALOG_MIC_POWERDOWN =
        microphone_port_setup_q[capture_path_pkg::BIT_ANALOG_MIC_POWERDOWN];
    // analog boost codes go straight to the amplifier
    assign RIGHT_ANALOG_BOOST = analog_mic_gain_select_q[
        capture_path_pkg::BOOST_R_LSB +: capture_path_pkg::BOOST_W];
    assign LEFT_ANALOG_BOOST  = analog_mic_gain_select_q[
        capture_path_pkg::BOOST_L_LSB +: capture_path_pkg::BOOST_W];

    // polarity flip on the raw mic bits
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MIC_BIT_A_OUT <= 1'b0;
            MIC_BIT_B_OUT <= 1'b0;
        end else begin
            MIC_BIT_A_OUT <= MIC_BIT_A
                ^ microphone_port_setup_q[capture_path_pkg::BIT_POLARITY];
            MIC_BIT_B_OUT <= MIC_BIT_B
                ^ microphone_port_setup_q[capture_path_pkg::BIT_POLARITY];
        end
    end

    capture_gain_stage #(.W(SAMPLE_W)) u_gain_left (
        .clk        (MCLK),
        .rst        (SYS_RST),
        .boost_code (adc1_boost_select_q[
            capture_path_pkg::BOOST_L_LSB +: capture_path_pkg::BOOST_W]),
        .gain_code  (adc1_left_digital_gain_q[
            capture_path_pkg::GAIN_LSB +: capture_path_pkg::GAIN_W]),
        .mute       (adc1_left_digital_gain_q[capture_path_pkg::BIT_MUTE]),
        .in_valid   (ADC1_VALID),
        .in_data    (ADC1_LEFT),
        .out_valid  (gl_valid),
        .out_data   (gl_data)
    );

    capture_gain_stage #(.W(SAMPLE_W)) u_gain_right (
        .clk        (MCLK),
        .rst        (SYS_RST),
        .boost_code (adc1_boost_select_q[
            capture_path_pkg::BOOST_R_LSB +: capture_path_pkg::BOOST_W]),
        .gain_code  (adc1_right_digital_gain_q[
            capture_path_pkg::GAIN_LSB +: capture_path_pkg::GAIN_W]),
        .mute       (adc1_right_digital_gain_q[capture_path_pkg::BIT_MUTE]),
        .in_valid   (ADC1_VALID),
        .in_data    (ADC1_RIGHT),
        .out_valid  (gr_valid),
        .out_data   (gr_data)
    );

    // mono copy taken after the exchange
    // right-only capture is exchange plus mono
    always_comb begin
        sw_left  = microphone_port_setup_q[capture_path_pkg::BIT_EXCHANGE]
                   ? gr_data : gl_data;
        sw_right = microphone_port_setup_q[capture_path_pkg::BIT_EXCHANGE]
                   ? gl_data : gr_data;
        if (microphone_port_setup_q[capture_path_pkg::BIT_MONO])
            sw_right = sw_left;
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            OUT_VALID <= 1'b0;
            OUT_LEFT  <= '0;
            OUT_RIGHT <= '0;
        end else begin
            OUT_VALID <= gl_valid && gr_valid;
            if (gl_valid) begin
                OUT_LEFT  <= sw_left;
                OUT_RIGHT <= sw_right;
            end
        end
    end

    // both paths write the same register
    a_uc_write_lands: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (UC_WR && !REG_WR && !REG_RD && UC_ADDR ==
         {capture_path_pkg::UC_PREFIX, capture_path_pkg::OFS_MIC_SETUP})
        |=> microphone_port_setup_q == $past(REG_WDATA))
        else $error("uc write not stored");
    a_mute_keeps_stream: assert property (@(posedge MCLK) disable iff (SYS_RST)
        ADC1_VALID |-> ##2 OUT_VALID)
        else $error("stream stalled");
    a_mute_silence: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (ADC1_VALID && adc1_left_digital_gain_q[7] &&
         microphone_port_setup_q[2:1] == 2'b00)
        |=> ##1 OUT_LEFT == '0)
        else $error("muted channel not silent");
    a_mono_copy: assert property (@(posedge MCLK) disable iff (SYS_RST)
        ($past(microphone_port_setup_q[2]) && $past(gl_valid))
        |-> OUT_RIGHT == OUT_LEFT)
        else $error("mono copy wrong");
    // exchange routes right gain to left output
    a_exchange_route: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (gl_valid && microphone_port_setup_q[1])
        |=> OUT_LEFT == $past(gr_data))
        else $error("exchange wrong");
    a_bit_invert: assert property (@(posedge MCLK) disable iff (SYS_RST)
        microphone_port_setup_q[3] |=> MIC_BIT_A_OUT == !$past(MIC_BIT_A))
        else $error("mic bit not inverted");
    a_pins_exclusive: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DIGITAL_PINS_EN != ANALOG_PINS_EN)
        else $error("pin function clash");
    a_reserved_readback: assert property (@(posedge MCLK)
        disable iff (SYS_RST)
        (REG_RD && REG_PAGE == 8'h01 && REG_OFFSET == 8'hb3)
        |=> REG_RDATA == adc0_filter_ctrl_q && REG_HIT)
        else $error("readback wrong");
endmodule : audio_capture_path_control
`default_nettype wire

// *** design/capture_path_pkg.sv ***
// register map, field positions and reset values of the capture path
`default_nettype none
package capture_path_pkg;
    // register page and microcontroller prefix
    localparam logic [7:0] PAGE_AUDIO       = 8'h01;
    localparam logic [7:0] UC_PREFIX        = 8'ha1;
    // register offsets
    localparam logic [7:0] OFS_ADC0_FILT    = 8'hb3;
    localparam logic [7:0] OFS_ADC1_LGAIN   = 8'hb4;
    localparam logic [7:0] OFS_ADC1_RGAIN   = 8'hb5;
    localparam logic [7:0] OFS_ADC1_BOOST   = 8'hb6;
    localparam logic [7:0] OFS_ADC1_FILT    = 8'hb7;
    localparam logic [7:0] OFS_MIC_SETUP    = 8'hb8;
    localparam logic [7:0] OFS_AMIC_GAIN    = 8'hb9;
    // reset values
    localparam logic [7:0] RST_FILT         = 8'h00;
    localparam logic [7:0] RST_GAIN         = 8'h8f;
    localparam logic [7:0] RST_BOOST        = 8'h33;
    localparam logic [7:0] RST_MIC_SETUP    = 8'h80;
    localparam logic [7:0] RST_AMIC_GAIN    = 8'h00;
    // field positions
    localparam int BIT_HPF_HOLD      = 4;
    localparam int BIT_HPF_BYPASS    = 6;
    localparam int BIT_MUTE          = 7;
    localparam int GAIN_LSB          = 0;
    localparam int GAIN_W            = 4;
    localparam int BOOST_R_LSB       = 0;
    localparam int BOOST_L_LSB       = 4;
    localparam int BOOST_W           = 2;
    localparam int BIT_MIC_TYPE      = 0;
    localparam int BIT_EXCHANGE      = 1;
    localparam int BIT_MONO          = 2;
    localparam int BIT_POLARITY      = 3;
    localparam int BIT_ANALOG_MIC_POWERDOWN      = 7;
    // sample stream width
    localparam int SAMPLE_W          = 24;
endpackage : capture_path_pkg
`default_nettype wire

// *** design/capture_gain_stage.sv ***
// one channel of digital boost, input gain and mute
`timescale 1ns/1ns
`default_nettype none
module capture_gain_stage #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // controls
    input  wire logic [1:0]   boost_code,
    input  wire logic [3:0]   gain_code,
    input  wire logic         mute,
    // stream
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    output logic [W-1:0]      out_data
);
    logic signed [W+8:0] boosted;
    logic signed [W+8:0] scaled;
    logic signed [W-1:0] sat;
    logic [3:0]          steps;

    // boost before gain
    // shifts approximate 10 dB steps; trades accuracy for no multiplier
    always_comb begin
        case (boost_code)
            2'h0: boosted = ($signed({{9{in_data[W-1]}}, in_data})) <<< 5;
            2'h1: boosted = ($signed({{9{in_data[W-1]}}, in_data})) <<< 3;
            2'h2: boosted = ($signed({{9{in_data[W-1]}}, in_data})) <<< 2;
            default: boosted = $signed({{9{in_data[W-1]}}, in_data});
        endcase
    end

    // code 0h is the largest gain
    // sixteen 1.5 dB steps: quarter steps, then one shift per 6 dB
    // keeps the top setting near 22.5 dB and inside the wide accumulator
    always_comb begin
        steps  = 4'hf - gain_code;
        scaled = boosted + (boosted >>> 2) * $signed({1'b0, steps[1:0]});
        scaled = scaled <<< steps[3:2];
        if (scaled > $signed({{10{1'b0}}, {(W-1){1'b1}}}))
            sat = {1'b0, {(W-1){1'b1}}};
        else if (scaled < -$signed({{10{1'b0}}, {(W-1){1'b1}}}))
            sat = {1'b1, {(W-2){1'b0}}, 1'b1};
        else
            sat = scaled[W-1:0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            out_valid <= 1'b0;
        else
            out_valid <= in_valid;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            out_data <= '0;
        else if (in_valid)
            out_data <= mute ? '0 : sat;
    end
endmodule : capture_gain_stage
`default_nettype wire

// *** bench/reg_host.sv ***
// host model issuing register accesses on the page path or the uc path
`timescale 1ns/1ns
`default_nettype none
module reg_host (
    // clock
    input  wire logic   clk,
    // register requests
    output logic        wr,
    output logic        rd,
    output logic [7:0]  page,
    output logic [7:0]  ofs,
    output logic        uc_wr,
    output logic        uc_rd,
    output logic [15:0] uc_addr,
    output logic [7:0]  wdata
);
    initial begin
        {wr, rd, uc_wr, uc_rd} = 4'h0;
        {page, ofs, uc_addr, wdata} = 40'h0;
    end
    // one access; pg is the page number, or the address prefix on uc path
    task automatic access(input logic uc, input logic w,
                          input logic [7:0] pg, input logic [7:0] o,
                          input logic [7:0] d);
        @(posedge clk);
        wr <= !uc && w;
        rd <= !uc && !w;
        uc_wr <= uc && w;
        uc_rd <= uc && !w;
        page <= pg;
        ofs <= o;
        uc_addr <= {pg, o};
        wdata <= d;
        @(posedge clk);
        {wr, rd, uc_wr, uc_rd} <= 4'h0;
        // released lines flip so a stale value never looks held
        page <= ~pg;
        ofs <= ~o;
        uc_addr <= ~{pg, o};
        wdata <= ~d;
    endtask : access
endmodule : reg_host
`default_nettype wire

// *** bench/test_audio_capture_path_control.sv ***
// self-checking bench of the capture path register bank and routing
`timescale 1ns/1ns
`default_nettype none
module test_audio_capture_path_control;
    localparam int W = capture_path_pkg::SAMPLE_W;
    logic         mclk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         mic_a = 1'b0;
    logic         mic_b = 1'b0;
    logic         adc_v = 1'b0;
    logic [W-1:0] adc_l = '0;
    logic [W-1:0] adc_r = '0;
    wire logic    wr, rd, uc_wr, uc_rd, hit, mo_a, mo_b, ov;
    wire logic [7:0]   page, ofs, wdata, rdata, lvl;
    wire logic [15:0]  uc_addr;
    wire logic [W-1:0] out_l, out_r;
    wire logic [1:0]   ab_l, ab_r;
    logic [7:0]   reg_q [$];
    logic [W-1:0] l_q [$];
    logic [W-1:0] r_q [$];
    logic [7:0]   v [7];
    logic [7:0]   e8;
    logic [W-1:0] el, er;
    int           error_cnt = 0;
    int           checks_done = 0;
    always #5 mclk = ~mclk;
    audio_capture_path_control audio_capture_path_control_inst (
        .MCLK(mclk), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd),
        .REG_PAGE(page), .REG_OFFSET(ofs), .UC_WR(uc_wr), .UC_RD(uc_rd),
        .UC_ADDR(uc_addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_HIT(hit), .MIC_BIT_A(mic_a), .MIC_BIT_B(mic_b),
        .MIC_BIT_A_OUT(mo_a), .MIC_BIT_B_OUT(mo_b), .ADC1_VALID(adc_v),
        .ADC1_LEFT(adc_l), .ADC1_RIGHT(adc_r), .OUT_VALID(ov),
        .OUT_LEFT(out_l), .OUT_RIGHT(out_r), .ADC0_HPF_HOLD(lvl[6]),
        .ADC0_HPF_BYPASS(lvl[7]), .ADC1_HPF_HOLD(lvl[4]),
        .ADC1_HPF_BYPASS(lvl[5]), .DIGITAL_MICROPHONE_PORT_SETUP(lvl[3]),
        .DIGITAL_PINS_EN(lvl[2]), .ANALOG_PINS_EN(lvl[1]),
        .ANALOG_MIC_POWERDOWN(lvl[0]), .LEFT_ANALOG_BOOST(ab_l),
        .RIGHT_ANALOG_BOOST(ab_r));
    reg_host reg_host_inst (
        .clk(mclk), .wr(wr), .rd(rd), .page(page), .ofs(ofs),
        .uc_wr(uc_wr), .uc_rd(uc_rd), .uc_addr(uc_addr), .wdata(wdata));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_smp(input logic [W-1:0] got, input logic [W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_smp
    task automatic wr_reg(input logic uc, input logic [7:0] o,
                          input logic [7:0] d);
        reg_q.push_back(8'h00);
        reg_host_inst.access(uc, 1'b1, uc ? capture_path_pkg::UC_PREFIX
                             : capture_path_pkg::PAGE_AUDIO, o, d);
    endtask : wr_reg
    task automatic read_all();
        for (int i = 0; i < 7; i++) begin
            reg_q.push_back(v[i]);
            reg_host_inst.access(1'b0, 1'b0, capture_path_pkg::PAGE_AUDIO,
                                 8'hb3 + 8'(i), 8'h00);
        end
        #1;
        // level outputs follow hold, bypass, mode and powerdown bits
        chk_reg(lvl, {v[0][6], v[0][4], v[4][6], v[4][4], v[5][0], v[5][0],
                !v[5][0], v[5][7]});
        // analog boost fields drive the boost outputs
        chk_reg({2'b00, ab_l, 2'b00, ab_r}, v[6] & 8'h33);
    endtask : read_all
    task automatic drain(input string name);
        int n;
        n = 0;
        while (reg_q.size() + l_q.size() != 0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (reg_q.size() + l_q.size() != 0) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, n, 0);
            end_of_test();
        end else
            $display("test %s done", name);
    endtask : drain
    // mute is applied per input channel, then exchange, then mono copy
    task automatic send(input logic [7:0] m, input logic lm);
        logic [W-1:0] l, r, a, b;
        repeat (4) begin
            l = W'($urandom);
            r = W'($urandom);
            a = lm ? '0 : l;
            b = m[1] ? a : r;
            a = m[1] ? r : a;
            l_q.push_back(a);
            r_q.push_back(m[2] ? a : b);
            @(posedge mclk);
            adc_v <= 1'b1;
            adc_l <= l;
            adc_r <= r;
        end
        @(posedge mclk);
        adc_v <= 1'b0;
        drain("stream");
    endtask : send
    always @(posedge mclk) begin
        if (hit === 1'b1) begin
            e8 = (reg_q.size() > 0) ? reg_q.pop_front() : 8'hxx;
            chk_reg(rdata, e8);
        end
        if (ov === 1'b1) begin
            el = (l_q.size() > 0) ? l_q.pop_front() : 'x;
            er = (r_q.size() > 0) ? r_q.pop_front() : 'x;
            chk_smp(out_l, el);
            chk_smp(out_r, er);
        end
    end
    initial begin
        void'($urandom(61526));
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        // reset values of every register and level output
        v = '{8'h00, 8'h8f, 8'h8f, 8'h33, 8'h00, 8'h80, 8'h00};
        read_all();
        drain("reset");
        // random writes through the uc path read back on the page path
        repeat (3) begin
            for (int i = 0; i < 7; i++) begin
                v[i] = 8'($urandom);
                wr_reg(1'b1, 8'hb3 + 8'(i), v[i]);
            end
            read_all();
        end
        drain("readback");
        // unmapped places are refused, stored values stay put
        for (int i = 0; i < 8; i++) begin
            // wrong page or prefix at a mapped offset, or a hole in the map
            reg_host_inst.access(i[0], i[1], i[2] ? (i[0] ? 8'ha0 : 8'h00)
                                 : (i[0] ? capture_path_pkg::UC_PREFIX
                                 : capture_path_pkg::PAGE_AUDIO),
                                 i[2] ? 8'hb8 : 8'hba, 8'h5a);
            #1;
            chk_reg({7'h00, hit} | rdata, 8'h00);
        end
        read_all();
        drain("unmapped");
        wr_reg(1'b0, 8'hb4, 8'h0f);
        wr_reg(1'b0, 8'hb5, 8'h0f);
        wr_reg(1'b0, 8'hb6, 8'h33);
        // stereo, exchange, mono and exchange with mono
        for (int m = 0; m < 8; m += 2) begin
            wr_reg(1'b0, 8'hb8, 8'(m));
            send(8'(m), 1'b0);
        end
        // muted left gives silence while the stream keeps flowing
        wr_reg(1'b0, 8'hb4, 8'h8f);
        wr_reg(1'b0, 8'hb8, 8'h00);
        send(8'h00, 1'b1);
        wr_reg(1'b0, 8'hb8, 8'h02);
        send(8'h02, 1'b1);
        for (int p = 0; p < 2; p++) begin
            wr_reg(1'b0, 8'hb8, 8'(p * 8));
            repeat (4) begin
                @(posedge mclk);
                mic_a <= 1'($urandom);
                mic_b <= 1'($urandom);
                @(posedge mclk);
                #1;
                chk_reg({mo_a, mo_b}, {mic_a, mic_b} ^ {2{p[0]}});
            end
        end
        drain("polarity");
        end_of_test();
    end
endmodule : test_audio_capture_path_control
`default_nettype wire
